// file: verilog/ddrb_defs.svh
// Constants for the two-word burst double-data-rate SRAM port.
`ifndef DDRB_DEFS_SVH
`define DDRB_DEFS_SVH

// Array organisation: 4 M locations of 36-bit words (the 8 M x 18 build uses 23 and 18).
`define DDRB_ADDR_WIDTH 22
`define DDRB_WORD_WIDTH 36
`define DDRB_ADDR_WIDTH_NARROW 23
`define DDRB_WORD_WIDTH_NARROW 18

// Each byte-write mask bit gates one lane of this many bits, lane 0 at the bottom.
`define DDRB_LANE_WIDTH 9

// Words moved per address.
`define DDRB_BURST_LEN 2

// Latency select encodings as seen on the bypass pin.
`define DDRB_LAT_ONE_CODE 1'h0
`define DDRB_LAT_TWO_HALF_CODE 1'h1

`endif

// file: verilog/ddrb_pkg.sv
// Types shared by the burst SRAM port.
`include "ddrb_defs.svh"

package ddrb_pkg;

    typedef enum logic
    {
        DDRB_LAT_ONE = `DDRB_LAT_ONE_CODE,
        DDRB_LAT_TWO_HALF = `DDRB_LAT_TWO_HALF_CODE
    } ddrb_lat_t;

endpackage

// file: verilog/ddrb_sync.sv
// Two-flop level synchroniser.
`timescale 1ns/1ps

module ddrb_sync
#(
    parameter int WIDTH = 1
)
(
    // Destination clock
    input wire logic clk,
    // Level from another domain
    input wire logic [WIDTH-1:0] d,
    // Synchronised level
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk)
    begin
        stage1 <= d;
        q <= stage1;
    end

endmodule

// file: verilog/ddrb_lane_mem.sv
// One byte lane of one burst word: synchronous write, combinational read.
`timescale 1ns/1ps

module ddrb_lane_mem
#(
    parameter int ADDR_WIDTH = 22,
    parameter int WIDTH = 9
)
(
    // Write port
    input wire logic clk,
    input wire logic we,
    input wire logic [ADDR_WIDTH-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read port
    input wire logic [ADDR_WIDTH-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [0:(1 << ADDR_WIDTH) - 1];

    always_ff @(posedge clk)
    begin
        if (we)
            mem[waddr] <= wdata;
    end

    assign rdata = mem[raddr];

endmodule

// file: verilog/ddrb_sram_port.sv
// Two-word burst double-data-rate SRAM port with echo clocks and read-valid flag.
`timescale 1ns/1ps
`include "ddrb_defs.svh"

// What this block does
// - One address taken per true-clock rising edge.
// - Write beats taken on true then complementary edge.
// - Read beats launched on alternating clock rising edges.
// - Each address holds two words, sequential burst.
// - Bypass high: read data after 2.5 cycles.
// - Bypass low: read data after one cycle.
// - Read-valid flag marks beats carrying read data.
// - Echo clocks aligned with read data.
// - All inputs registered before the core.
// - Data outputs come from output registers.
// - Writes reach the array on internal timing.
// - Shared data pins; driven only for reads.
// - Only rising edges of both clocks used.
// - Array is 8M x 18 or 4M x 36.
// - Low mask bits enable 9-bit lane writes.
// - Data pins released when no read active.
module ddrb_sram_port
#(
    parameter int ADDR_WIDTH = `DDRB_ADDR_WIDTH,
    parameter int WORD_WIDTH = `DDRB_WORD_WIDTH,
    parameter int LANES = WORD_WIDTH / `DDRB_LANE_WIDTH
)
(
    // System clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Link clocks, complementary pair
    input wire logic kClk,
    input wire logic kClkN,
    // Command
    input wire logic loadStrobeN,
    input wire logic readWriteSelect,
    input wire logic [ADDR_WIDTH-1:0] address,
    // Shared data pins and byte masks
    input wire logic [WORD_WIDTH-1:0] dqIn,
    output logic [WORD_WIDTH-1:0] dqOut,
    output logic dqOe,
    input wire logic [LANES-1:0] byteWriteMaskN,
    // Read timing outputs
    output logic echoTimingOut,
    output logic echoTimingOutN,
    output logic readValidFlag,
    // Latency configuration and status
    input wire logic pllBypassSelect,
    output ddrb_pkg::ddrb_lat_t latencyMode,
    output logic commandSeen
);

    import ddrb_pkg::*;

    logic bypassRef;
    logic modeRef;
    logic modeK;
    logic kRstN;
    logic cmdSeenK;

    // The strap is synchronised, then caught while reset is held.
    ddrb_sync #(.WIDTH(1)) bypassSyncInst
    (
        .clk(ref_clk),
        .d(pllBypassSelect),
        .q(bypassRef)
    );

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            modeRef <= bypassRef;
    end

    assign latencyMode = ddrb_lat_t'(modeRef);

    // Mode and reset cross into the link domain as levels.
    ddrb_sync #(.WIDTH(2)) linkSyncInst
    (
        .clk(kClk),
        .d({modeRef, rst_n}),
        .q({modeK, kRstN})
    );

    ddrb_sync #(.WIDTH(1)) seenSyncInst
    (
        .clk(ref_clk),
        .d(cmdSeenK),
        .q(commandSeen)
    );

    // Command input registers on the true clock.
    logic rdCmdA;
    logic wrCmdA;
    logic [ADDR_WIDTH-1:0] addrA;
    wire cmdRead = !loadStrobeN && readWriteSelect;
    wire cmdWrite = !loadStrobeN && !readWriteSelect;

    always_ff @(posedge kClk)
    begin
        if (!kRstN)
        begin
            rdCmdA <= 1'h0;
            wrCmdA <= 1'h0;
            cmdSeenK <= 1'h0;
        end
        else
        begin
            rdCmdA <= cmdRead;
            wrCmdA <= cmdWrite;
            cmdSeenK <= cmdSeenK || cmdRead || cmdWrite;
        end
    end

    always_ff @(posedge kClk)
    begin
        addrA <= address;
    end

    // Write beats: first on the true clock, second on the complementary clock.
    logic [WORD_WIDTH-1:0] dataK;
    logic [WORD_WIDTH-1:0] dataKn;
    logic [LANES-1:0] maskK;
    logic [LANES-1:0] maskKn;
    logic wrPend1;
    logic [ADDR_WIDTH-1:0] wrAddr1;

    always_ff @(posedge kClkN)
    begin
        dataKn <= dqIn;
        maskKn <= byteWriteMaskN;
    end

    // Read pipeline: array read, then a held copy for the longer latency.
    logic rdPend1;
    logic latePend;
    logic [WORD_WIDTH-1:0] memRd0;
    logic [WORD_WIDTH-1:0] memRd1;
    logic [WORD_WIDTH-1:0] rdWord0;
    logic [WORD_WIDTH-1:0] rdWord1;
    logic [WORD_WIDTH-1:0] lateWord0;
    logic [WORD_WIDTH-1:0] lateWord1;

    always_ff @(posedge kClk)
    begin
        dataK <= dqIn;
        maskK <= byteWriteMaskN;
        wrAddr1 <= addrA;
        rdWord0 <= memRd0;
        rdWord1 <= memRd1;
        lateWord0 <= rdWord0;
        lateWord1 <= rdWord1;
    end

    always_ff @(posedge kClk)
    begin
        if (!kRstN)
        begin
            wrPend1 <= 1'h0;
            rdPend1 <= 1'h0;
            latePend <= 1'h0;
        end
        else
        begin
            wrPend1 <= wrCmdA;
            rdPend1 <= rdCmdA;
            latePend <= rdPend1;
        end
    end

    // Array: one lane memory per byte lane and burst word, written on the true-clock edge
    // half a cycle after the last beat without any host strobe.
    logic [LANES-1:0] laneWe0;
    logic [LANES-1:0] laneWe1;

    genvar gl;
    generate
        for (gl = 0; gl < LANES; gl++)
        begin : gLane
            localparam int LO = gl * `DDRB_LANE_WIDTH;
            assign laneWe0[gl] = wrPend1 && !maskK[gl];
            assign laneWe1[gl] = wrPend1 && !maskKn[gl];
            ddrb_lane_mem #(.ADDR_WIDTH(ADDR_WIDTH), .WIDTH(`DDRB_LANE_WIDTH)) beat0Inst
            (
                .clk(kClk),
                .we(laneWe0[gl]),
                .waddr(wrAddr1),
                .wdata(dataK[LO +: `DDRB_LANE_WIDTH]),
                .raddr(addrA),
                .rdata(memRd0[LO +: `DDRB_LANE_WIDTH])
            );
            ddrb_lane_mem #(.ADDR_WIDTH(ADDR_WIDTH), .WIDTH(`DDRB_LANE_WIDTH)) beat1Inst
            (
                .clk(kClk),
                .we(laneWe1[gl]),
                .waddr(wrAddr1),
                .wdata(dataKn[LO +: `DDRB_LANE_WIDTH]),
                .raddr(addrA),
                .rdata(memRd1[LO +: `DDRB_LANE_WIDTH])
            );
        end
    endgenerate

    // Beat launched at each edge; the mode picks one-cycle or 2.5-cycle timing.
    wire kLaunchValid = modeK ? latePend : rdCmdA;
    wire knLaunchValid = modeK ? latePend : rdPend1;
    wire [WORD_WIDTH-1:0] kLaunchData = modeK ? lateWord1 : memRd0;
    wire [WORD_WIDTH-1:0] knLaunchData = modeK ? lateWord0 : rdWord1;
    wire [WORD_WIDTH-1:0] kBeat = kLaunchValid ? kLaunchData : '0;
    wire [WORD_WIDTH-1:0] knBeat = knLaunchValid ? knLaunchData : '0;

    // Output registers on both rising edges; each pair is combined by XOR, so the
    // pin follows whichever register updated last with no clock in the data path.
    logic [WORD_WIDTH-1:0] dqK;
    logic [WORD_WIDTH-1:0] dqKn;
    logic validK;
    logic validKn;
    logic echoK;
    logic echoKn;

    always_ff @(posedge kClk)
    begin
        if (!kRstN)
        begin
            dqK <= '0;
            validK <= 1'h0;
            echoK <= 1'h0;
        end
        else
        begin
            dqK <= kBeat ^ dqKn;
            validK <= kLaunchValid ^ validKn;
            echoK <= ~echoKn;
        end
    end

    always_ff @(posedge kClkN)
    begin
        if (!kRstN)
        begin
            dqKn <= '0;
            validKn <= 1'h0;
            echoKn <= 1'h0;
        end
        else
        begin
            dqKn <= knBeat ^ dqK;
            validKn <= knLaunchValid ^ validK;
            echoKn <= echoK;
        end
    end

    assign dqOut = dqK ^ dqKn;
    assign readValidFlag = validK ^ validKn;
    assign dqOe = validK ^ validKn;
    assign echoTimingOut = echoK ^ echoKn;
    assign echoTimingOutN = ~(echoK ^ echoKn);

    a_write_addr_taken: assert property (@(posedge kClk) disable iff (!kRstN)
        wrCmdA |=> (wrPend1 && wrAddr1 == $past(addrA)))
        else $error("write address not carried to the commit stage");

    a_mask_lane_gate: assert property (@(posedge kClk) disable iff (!kRstN)
        (wrPend1 && maskK == '1 && maskKn == '1) |-> (laneWe0 == '0 && laneWe1 == '0))
        else $error("masked lane written");

    a_one_cycle_lat: assert property (@(posedge kClk) disable iff (!kRstN)
        (rdCmdA && !modeK) |=> (readValidFlag && dqOe))
        else $error("one-cycle read data missing");

    a_half_lat_valid: assert property (@(posedge kClk) disable iff (!kRstN)
        (rdCmdA && modeK) |=> ##1 (readValidFlag && dqOe))
        else $error("2.5-cycle read data missing");

    a_first_beat_word: assert property (@(posedge kClkN) disable iff (!kRstN)
        (rdPend1 && !modeK) |-> (dqOut == rdWord0 && readValidFlag))
        else $error("first burst word wrong on true-clock beat");

    a_second_beat_word: assert property (@(posedge kClk) disable iff (!kRstN)
        (rdPend1 && !modeK) |-> (dqOut == rdWord1))
        else $error("second burst word wrong on complementary beat");

    a_late_first_word: assert property (@(posedge kClk) disable iff (!kRstN)
        (latePend && modeK) |-> (dqOut == lateWord0 && readValidFlag))
        else $error("late first word wrong");

    a_idle_bus_free: assert property (@(posedge kClk) disable iff (!kRstN)
        (!rdCmdA && !rdPend1 && !latePend) |=> (!dqOe && !readValidFlag))
        else $error("data pins driven with no read active");

    a_echo_low_at_k: assert property (@(posedge kClk) disable iff (!kRstN)
        $past(kRstN) |-> (!echoTimingOut && echoTimingOutN))
        else $error("echo clock not low before true edge");

    // The first complementary edge after reset still sees both echo flops cleared.
    a_echo_high_at_kn: assert property (@(posedge kClkN) disable iff (!kRstN)
        $past(kRstN) |-> echoTimingOut)
        else $error("echo clock not high before complementary edge");

endmodule

// file: testbench/ddrb_host_model.sv
// Host memory controller model driving the burst SRAM pins.
`timescale 1ns/1ps

module ddrb_host_model
(
    // Link clocks
    input wire logic kClk,
    input wire logic kClkN,
    // Command and write data
    output logic loadStrobeN,
    output logic readWriteSelect,
    output logic [9:0] address,
    output logic [35:0] dqIn,
    output logic [3:0] byteWriteMaskN,
    // Read return
    input wire logic [35:0] dqOut,
    input wire logic dqOe,
    input wire logic readValidFlag,
    input wire logic echoTimingOut
);
    initial
    begin
        loadStrobeN = 1'h1;
        readWriteSelect = 1'h1;
        address = 10'h000;
        dqIn = 36'h0;
        byteWriteMaskN = 4'hF;
    end

    task automatic send_cmd(input logic rd, input logic [9:0] a);
        @(posedge kClk);
        #1;
        loadStrobeN = 1'h0;
        readWriteSelect = rd;
        address = a;
        @(posedge kClk);
        #1;
        loadStrobeN = 1'h1;
        address = ~a;
    endtask

    task automatic write_burst(input logic [9:0] a, input logic [35:0] w0, w1,
        input logic [3:0] m0, m1);
        send_cmd(1'h0, a);
        dqIn = w0;
        byteWriteMaskN = m0;
        @(posedge kClk);
        #1;
        dqIn = w1;
        byteWriteMaskN = m1;
        @(posedge kClkN);
        #1;
        // Released pins show the inverse, so a stale capture cannot look right.
        dqIn = ~w1;
        byteWriteMaskN = 4'hF;
    endtask

    task automatic read_burst(input logic [9:0] a, input logic lat,
        output logic [35:0] r0, r1, output logic [2:0] st);
        send_cmd(1'h1, a);
        if (lat)
        begin
            repeat (2) @(posedge kClk);
            @(posedge kClkN);
        end
        else
            @(posedge kClk);
        #2;
        r0 = dqOut;
        st[0] = readValidFlag === 1'h1 && dqOe === 1'h1 && echoTimingOut === !lat;
        if (lat)
            @(posedge kClk);
        else
            @(posedge kClkN);
        #2;
        r1 = dqOut;
        st[1] = readValidFlag === 1'h1 && dqOe === 1'h1 && echoTimingOut === lat;
        if (lat)
            @(posedge kClkN);
        else
            @(posedge kClk);
        #2;
        st[2] = readValidFlag === 1'h0 && dqOe === 1'h0;
    endtask
endmodule

// file: testbench/ddr_burst2_sram_interface_tb.sv
// Self-checking bench for the burst SRAM port.
`timescale 1ns/1ps

module ddr_burst2_sram_interface_tb;
    import ddrb_pkg::*;
    logic ref_clk, rst_n, kClk, kClkN, pllBypassSelect, loadStrobeN, readWriteSelect;
    logic [9:0] address;
    logic [35:0] dqIn, dqOut;
    logic [3:0] byteWriteMaskN;
    logic dqOe, echoTimingOut, echoTimingOutN, readValidFlag, commandSeen;
    ddrb_lat_t latencyMode;
    int error_cnt = 0;
    int samples_checked = 0;

    ddrb_sram_port #(.ADDR_WIDTH(10)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .kClk(kClk),
        .kClkN(kClkN), .loadStrobeN(loadStrobeN), .readWriteSelect(readWriteSelect),
        .address(address), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
        .byteWriteMaskN(byteWriteMaskN), .echoTimingOut(echoTimingOut),
        .echoTimingOutN(echoTimingOutN), .readValidFlag(readValidFlag),
        .pllBypassSelect(pllBypassSelect), .latencyMode(latencyMode),
        .commandSeen(commandSeen));
    ddrb_host_model host_u (.kClk(kClk), .kClkN(kClkN), .loadStrobeN(loadStrobeN),
        .readWriteSelect(readWriteSelect), .address(address), .dqIn(dqIn),
        .byteWriteMaskN(byteWriteMaskN), .dqOut(dqOut), .dqOe(dqOe),
        .readValidFlag(readValidFlag), .echoTimingOut(echoTimingOut));

    initial
    begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial
    begin
        kClk = 1'h0;
        #3;
        forever #7.5 kClk = ~kClk;
    end
    assign kClkN = ~kClk;

    task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] m);
        logic [35:0] r;
        for (int i = 0; i < 4; i++)
            r[9*i +: 9] = m[i] ? o[9*i +: 9] : n[9*i +: 9];
        return r;
    endfunction

    task automatic t_reset(input logic lat);
        @(negedge ref_clk);
        rst_n <= 1'h0;
        pllBypassSelect <= lat;
        repeat (20) @(negedge ref_clk);
        check(36'(dqOe), 36'h0, "pins driven in reset");
        check(36'(echoTimingOut ^ echoTimingOutN), 36'h1, "echo pair");
        check(36'(latencyMode), 36'(lat), "latency strap");
        rst_n <= 1'h1;
        repeat (2) @(negedge ref_clk);
        check(36'(commandSeen), 36'h0, "status after reset");
        $display("test reset done");
    endtask

    task automatic t_burst(input logic lat);
        logic [35:0] r0, r1;
        logic [2:0] st;
        host_u.write_burst(10'h005, 36'h123456789 ^ {36{lat}}, 36'hFEDCBA987, 4'h0, 4'h0);
        host_u.read_burst(10'h005, lat, r0, r1, st);
        check(r0, 36'h123456789 ^ {36{lat}}, "burst word0");
        check(r1, 36'hFEDCBA987, "burst word1");
        check(36'(st), 36'h7, "valid echo release");
        repeat (3) @(negedge ref_clk);
        check(36'(commandSeen), 36'h1, "command status");
        $display("test burst done");
    endtask

    task automatic t_mask(input logic lat);
        logic [35:0] r0, r1;
        logic [2:0] st;
        host_u.write_burst(10'h3FF, 36'hAAAAAAAAA, 36'h555555555 ^ {36{lat}}, 4'h0, 4'h0);
        host_u.write_burst(10'h3FF, 36'h0F0F0F0F0, 36'h3C3C3C3C3, 4'h5, 4'hA);
        host_u.write_burst(10'h3FF, 36'h000000000, 36'hFFFFFFFFF, 4'hF, 4'hF);
        host_u.read_burst(10'h3FF, lat, r0, r1, st);
        check(r0, merge(36'hAAAAAAAAA, 36'h0F0F0F0F0, 4'h5), "masked word0");
        check(r1, merge(36'h555555555 ^ {36{lat}}, 36'h3C3C3C3C3, 4'hA), "masked word1");
        check(36'(st), 36'h7, "masked read timing");
        $display("test mask done");
    endtask

    initial
    begin
        rst_n = 1'h0;
        pllBypassSelect = 1'h0;
        t_reset(1'h0);
        t_burst(1'h0);
        t_mask(1'h0);
        t_reset(1'h1);
        t_burst(1'h1);
        t_mask(1'h1);
        tally_and_finish();
    end

    initial
    begin
        for (int i = 0; i < 60000; i++)
            @(posedge ref_clk);
        error_cnt++;
        tally_and_finish();
    end
endmodule
